// [verilog/ddrsr_params.svh]
// Constants for the dual-port burst SRAM interface
`ifndef DDRSR_PARAMS_SVH
`define DDRSR_PARAMS_SVH
`define DDRSR_DATA_W        18
`define DDRSR_ADDR_W        8
`define DDRSR_FIFO_DEPTH    16
`define DDRSR_LAT_LONG_HALF 5
`define DDRSR_LAT_SHORT_HALF 2
`define DDRSR_RST_DATA      18'h00000
`endif

// [verilog/ddrsr_pkg.sv]
// Types shared by the dual-port burst SRAM interface
`include "ddrsr_params.svh"
package ddrsr_pkg;
  typedef struct packed {
    logic [`DDRSR_ADDR_W-1:0] addr;
    logic [`DDRSR_DATA_W-1:0] word0;
    logic [`DDRSR_DATA_W-1:0] word1;
  } ddrsr_wr_type;
  typedef enum logic [1:0] {
    DDRSR_PH_IDLE  = 2'b00,
    DDRSR_PH_BEAT0 = 2'b01,
    DDRSR_PH_BEAT1 = 2'b11
  } ddrsr_ph_type;
endpackage

// [verilog/ddrsr_fifo.sv]
// Write staging FIFO with valid/ready on both sides
`timescale 1ns/10ps
module ddrsr_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic             i_sys_clk,
  input  wire logic             i_sys_rst,
  // Fill side
  input  wire logic             i_in_valid,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_in_ready,
  // Drain side
  output logic                  o_out_valid,
  output logic [WIDTH-1:0]      o_out_data,
  input  wire logic             i_out_ready
);
  localparam int AW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) $error("DEPTH must be a power of two");
  end
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW:0]      wp_reg;
  logic [AW:0]      rp_reg;
  wire              push = i_in_valid && o_in_ready;
  wire              pop  = o_out_valid && i_out_ready;
  // Honest full and empty flags from pointer compare
  assign o_in_ready  = (wp_reg - rp_reg) != (AW+1)'(DEPTH);
  assign o_out_valid = wp_reg != rp_reg;
  assign o_out_data  = mem_reg[rp_reg[AW-1:0]];
  // Storage
  always_ff @(posedge i_sys_clk) begin
    if (push) mem_reg[wp_reg[AW-1:0]] <= i_in_data;
  end
  // Pointers
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      wp_reg <= '0;
      rp_reg <= '0;
    end else begin
      wp_reg <= wp_reg + (AW+1)'(push);
      rp_reg <= rp_reg + (AW+1)'(pop);
    end
  end
endmodule

// [verilog/ddrsr_core.sv]
// Dual-port two-word burst SRAM with DDR ports, echo clocks and valid flag
`timescale 1ns/10ps
`include "ddrsr_params.svh"
module ddrsr_core
  import ddrsr_pkg::*;
#(
  parameter int DATA_W     = `DDRSR_DATA_W,
  parameter int ADDR_W     = `DDRSR_ADDR_W,
  parameter int FIFO_DEPTH = `DDRSR_FIFO_DEPTH
) (
  // System clock and reset
  input  wire logic              i_sys_clk,
  input  wire logic              i_sys_rst,
  // Link clocks from the controller
  input  wire logic              i_k_clk,
  input  wire logic              i_k_clk_n,
  // Shared address and port selects, active low
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic              i_rd_sel_n,
  input  wire logic              i_wr_sel_n,
  // Write data and latency mode
  input  wire logic [DATA_W-1:0] i_wr_data,
  input  wire logic              i_latency_mode_pin,
  // Read data, valid and echo clocks
  output logic [DATA_W-1:0]      o_rd_data,
  output logic                   o_read_valid_flag,
  output logic                   o_echo_clock_out,
  output logic                   o_echo_clock_out_n,
  // Write back-pressure: staging full
  output logic                   o_wr_stall
);
  import ddrsr_pkg::*;

  // Parameter values the logic cannot serve are reported by $error when simulation starts
  initial begin
    if (DATA_W != 18 && DATA_W != 36) $error("DATA_W must be 18 or 36");
    if (ADDR_W < 1 || ADDR_W > 16) $error("ADDR_W out of range");
    if (FIFO_DEPTH < 2) $error("FIFO_DEPTH must be at least 2");
  end

  // Array depth, read pipeline length in beats and write packet width
  localparam int DEPTH   = 1 << ADDR_W;
  localparam int PIPE_N  = 8;
  localparam int WR_W    = ADDR_W + 2 * DATA_W;

  // The pending-read shifter must reach the longest latency, and the
  // packet type must match the packet width that the FIFO carries
  initial begin
    if (`DDRSR_LAT_LONG_HALF > PIPE_N) $error("Read pipeline too short for the latency");
    if (WR_W != $bits(ddrsr_wr_type)) $error("Packet type width differs from WR_W");
  end

  // Two-flop synchronisers for every pin
  logic [ADDR_W-1:0] addr_s1_reg;
  logic [ADDR_W-1:0] addr_s2_reg;
  logic [DATA_W-1:0] wd_s1_reg;
  logic [DATA_W-1:0] wd_s2_reg;
  logic [4:0]        ctl_s1_reg;
  logic [4:0]        ctl_s2_reg;
  logic [1:0]        clk_d_reg;

  // Data pins need no reset: they are only read under a qualifying edge
  always_ff @(posedge i_sys_clk) begin
    addr_s1_reg <= i_addr;
    addr_s2_reg <= addr_s1_reg;
    wd_s1_reg   <= i_wr_data;
    wd_s2_reg   <= wd_s1_reg;
  end

  // Control pins reset to read port deselected, write select low, K low and K# high
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      ctl_s1_reg <= 5'h03 << 1;
      ctl_s2_reg <= 5'h03 << 1;
      clk_d_reg  <= 2'h0;
    end else begin
      ctl_s1_reg <= {i_latency_mode_pin, i_wr_sel_n, i_rd_sel_n, i_k_clk_n, i_k_clk};
      ctl_s2_reg <= ctl_s1_reg;
      clk_d_reg  <= ctl_s2_reg[1:0];
    end
  end

  // Rising-edge detection only; falling edges are never used
  wire k_rise    = ctl_s2_reg[0] && !clk_d_reg[0];
  wire kn_rise   = ctl_s2_reg[1] && !clk_d_reg[1];
  wire beat      = k_rise || kn_rise;
  wire rd_sel    = !ctl_s2_reg[2];
  wire wr_sel    = !ctl_s2_reg[3];
  wire long_lat  = ctl_s2_reg[4];

  // Address phase alternates read then write on K rises
  logic              addr_ph_reg;   // 0: read address edge, 1: write address edge
  wire               rd_take  = k_rise && !addr_ph_reg && rd_sel;
  wire               wr_take  = k_rise &&  addr_ph_reg && wr_sel;

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) addr_ph_reg <= 1'b0;
    else if (k_rise) addr_ph_reg <= !addr_ph_reg;
  end

  // Write burst capture: two beats following the write address.
  // The phase walks idle, first beat, second beat; each K or K# rise
  // is one data beat, so a burst takes one full link period.
  ddrsr_ph_type      wph_reg;
  logic [ADDR_W-1:0] waddr_reg;
  logic [DATA_W-1:0] wword0_reg;
  ddrsr_wr_type      wpkt;
  logic              wpush_reg;
  logic [WR_W-1:0]   wpkt_reg;

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      wph_reg   <= DDRSR_PH_IDLE;
      wpush_reg <= 1'b0;
    end else begin
      wpush_reg <= 1'b0;
      unique case (wph_reg)
        DDRSR_PH_IDLE:  if (wr_take) wph_reg <= DDRSR_PH_BEAT0;
        DDRSR_PH_BEAT0: if (beat) wph_reg <= DDRSR_PH_BEAT1;
        DDRSR_PH_BEAT1: if (beat) begin
          wph_reg   <= DDRSR_PH_IDLE;
          wpush_reg <= 1'b1;
        end
        default:        wph_reg <= DDRSR_PH_IDLE;
      endcase
    end
  end

  // Address and first word are held until the packet is complete
  always_ff @(posedge i_sys_clk) begin
    if (wr_take) waddr_reg <= addr_s2_reg;
    if (wph_reg == DDRSR_PH_BEAT0 && beat) wword0_reg <= wd_s2_reg;
    if (wph_reg == DDRSR_PH_BEAT1 && beat) wpkt_reg <= {waddr_reg, wword0_reg, wd_s2_reg};
  end

  // Write staging FIFO drains into the array on its own timing.
  // It is drained every cycle, so it never holds more than one packet;
  // the stall output never asserts at any link clock rate.
  logic              f_valid;
  logic [WR_W-1:0]   f_data;
  logic              f_in_ready;
  wire               f_pop = f_valid;
  assign wpkt = ddrsr_wr_type'(f_data);

  ddrsr_fifo #(
    .WIDTH (WR_W),
    .DEPTH (FIFO_DEPTH)
  ) u_wr_fifo (
    .i_sys_clk   (i_sys_clk),
    .i_sys_rst   (i_sys_rst),
    .i_in_valid  (wpush_reg),
    .i_in_data   (wpkt_reg),
    .o_in_ready  (f_in_ready),
    .o_out_valid (f_valid),
    .o_out_data  (f_data),
    .i_out_ready (f_pop)
  );

  // Memory array, two words per address
  logic [2*DATA_W-1:0] mem_reg [DEPTH];
  always_ff @(posedge i_sys_clk) begin
    if (f_pop) mem_reg[wpkt.addr] <= {wpkt.word0, wpkt.word1};
  end

  // Coherency: newest pending write wins over array contents.
  // A read may land on the very edge that brings the second write beat,
  // on the cycle the packet is pushed, or while it waits in the FIFO.
  // The candidates are checked newest first, the array last.
  wire               hit_q = f_valid && wpkt.addr == addr_s2_reg;
  wire               hit_p = wpush_reg && wpkt_reg[WR_W-1 -: ADDR_W] == addr_s2_reg;
  wire               hit_c = (wph_reg == DDRSR_PH_BEAT1) && beat && waddr_reg == addr_s2_reg;
  wire [2*DATA_W-1:0] pair_c = {wword0_reg, wd_s2_reg};
  wire [2*DATA_W-1:0] pair_p = wpkt_reg[2*DATA_W-1:0];
  wire [2*DATA_W-1:0] pair_q = {wpkt.word0, wpkt.word1};
  wire [2*DATA_W-1:0] pair_m = mem_reg[addr_s2_reg];
  wire [2*DATA_W-1:0] rd_pair =
    hit_c ? pair_c :
    hit_p ? pair_p :
    hit_q ? pair_q : pair_m;

  // Read pipeline: counts beats (half cycles) from address capture.
  // The long latency spans five beats while reads may come every four
  // beats, so two reads can be in flight: each keeps its own pair slot
  // and its own bit in the pending shifter.
  logic [2*DATA_W-1:0] rpair_reg [2];
  logic                rwr_sel_reg;   // Slot the next captured read fills
  logic                rrd_sel_reg;   // Slot the output stage drains
  logic [PIPE_N-1:0]   rpend_reg;
  logic [1:0]          rbeat_reg;
  wire [3:0]           lat_beats = long_lat ? 4'(`DDRSR_LAT_LONG_HALF)
                                            : 4'(`DDRSR_LAT_SHORT_HALF);
  wire                 rd_start  = beat && rpend_reg[0];
  wire                 rd_last   = beat && rbeat_reg == 2'h1;
  wire [2*DATA_W-1:0]  rout_pair = rpair_reg[rrd_sel_reg];

  // Older reads keep shifting while a new one is inserted beside them
  wire [PIPE_N-1:0]    rpend_shift = beat ? (rpend_reg >> 1) : rpend_reg;
  wire [PIPE_N-1:0]    rpend_new   = rd_take ? (PIPE_N'(1) << (lat_beats - 4'h1)) : '0;
  wire [PIPE_N-1:0]    rpend_next  = rpend_shift | rpend_new;

  // Pair capture at the read address edge
  always_ff @(posedge i_sys_clk) begin
    if (rd_take) rpair_reg[rwr_sel_reg] <= rd_pair;
  end

  // Pending shifter and slot pointers
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      rpend_reg   <= '0;
      rwr_sel_reg <= 1'b0;
      rrd_sel_reg <= 1'b0;
    end else begin
      rpend_reg <= rpend_next;
      if (rd_take) rwr_sel_reg <= !rwr_sel_reg;
      if (rd_last) rrd_sel_reg <= !rrd_sel_reg;
    end
  end

  // Output registers: data and valid flag, one word per beat
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      rbeat_reg          <= 2'h0;
      o_rd_data          <= DATA_W'(`DDRSR_RST_DATA);
      o_read_valid_flag  <= 1'b0;
    end else if (rd_start) begin
      rbeat_reg          <= 2'h1;
      o_rd_data          <= rout_pair[2*DATA_W-1 -: DATA_W];
      o_read_valid_flag  <= 1'b1;
    end else if (rd_last) begin
      rbeat_reg          <= 2'h2;
      o_rd_data          <= rout_pair[DATA_W-1:0];
    end else if (beat && rbeat_reg == 2'h2) begin
      rbeat_reg          <= 2'h0;
      o_read_valid_flag  <= 1'b0;
    end
  end

  // Echo clocks rebuilt from the detected link rises, so they keep the
  // same delay as the read data launched from those rises
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      o_echo_clock_out   <= 1'b0;
      o_echo_clock_out_n <= 1'b1;
    end else if (k_rise) begin
      o_echo_clock_out   <= 1'b1;
      o_echo_clock_out_n <= 1'b0;
    end else if (kn_rise) begin
      o_echo_clock_out   <= 1'b0;
      o_echo_clock_out_n <= 1'b1;
    end
  end

  // Staging full flag, one cycle late
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) o_wr_stall <= 1'b0;
    else           o_wr_stall <= !f_in_ready;
  end
endmodule

// [tb/ddrsr_core_chk.sv]
// Port timing checker for the burst SRAM interface
`timescale 1ns/10ps
module ddrsr_core_chk #(
  parameter int DATA_W = 18
) (
  // Clock, reset and link side
  input wire logic              i_sys_clk,
  input wire logic              i_sys_rst,
  input wire logic              i_k_clk,
  input wire logic              i_k_clk_n,
  input wire logic              i_rd_sel_n,
  input wire logic              i_latency_mode_pin,
  // Read side
  input wire logic [DATA_W-1:0] o_rd_data,
  input wire logic              o_read_valid_flag,
  input wire logic              o_echo_clock_out,
  input wire logic              o_echo_clock_out_n
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_sys_rst);
  logic       k_reg;
  logic       rd_ph_reg;
  logic [7:0] since_rd_reg;
  wire        k_rise  = i_k_clk & ~k_reg;
  wire        rd_edge = k_rise & rd_ph_reg & ~i_rd_sel_n;
  // Raw link edges: read edge first after reset, then alternating
  always_ff @(posedge i_sys_clk) begin
    k_reg        <= i_k_clk;
    rd_ph_reg    <= i_sys_rst ? 1'b1 : rd_ph_reg ^ k_rise;
    since_rd_reg <= i_sys_rst ? 8'hFF : rd_edge ? 8'h00 :
                    since_rd_reg + {7'h00, since_rd_reg != 8'hFF};
  end
  // Port relations
  property p_rst_vals;
    @(posedge i_sys_clk) disable iff (1'b0) i_sys_rst |=> !o_read_valid_flag &&
      !o_echo_clock_out && o_echo_clock_out_n && o_rd_data == '0;
  endproperty
  a_rst_vals: assert property (p_rst_vals)
    else $error("Outputs not at reset values");
  property p_echo_pair;
    o_echo_clock_out_n != o_echo_clock_out;
  endproperty
  a_echo_pair: assert property (p_echo_pair)
    else $error("Echo clocks not complementary");
  property p_echo_rise;
    $rose(i_k_clk) |-> ##[1:6] $rose(o_echo_clock_out);
  endproperty
  a_echo_rise: assert property (p_echo_rise)
    else $error("Echo clock did not follow true clock rise");
  property p_echo_fall;
    $rose(i_k_clk_n) |-> ##[1:6] $fell(o_echo_clock_out);
  endproperty
  a_echo_fall: assert property (p_echo_fall)
    else $error("Echo clock did not follow complement clock rise");
  property p_lat_long;
    rd_edge && i_latency_mode_pin |-> ##[48:60] o_read_valid_flag;
  endproperty
  a_lat_long: assert property (p_lat_long)
    else $error("Long latency read data missing");
  property p_lat_short;
    rd_edge && !i_latency_mode_pin |-> ##[18:30] o_read_valid_flag;
  endproperty
  a_lat_short: assert property (p_lat_short)
    else $error("Short latency read data missing");
  property p_valid_span;
    $rose(o_read_valid_flag) |=> o_read_valid_flag [*8];
  endproperty
  a_valid_span: assert property (p_valid_span)
    else $error("Valid flag shorter than a burst");
  property p_valid_cause;
    o_read_valid_flag |-> since_rd_reg <= 8'h50;
  endproperty
  a_valid_cause: assert property (p_valid_cause)
    else $error("Valid flag without a selected read");
  c_long: cover property (rd_edge && i_latency_mode_pin);
  c_short: cover property (rd_edge && !i_latency_mode_pin);
  c_desel: cover property (k_rise && rd_ph_reg && i_rd_sel_n);
endmodule
bind ddrsr_core ddrsr_core_chk #(.DATA_W(DATA_W)) u_chk (
  .i_sys_clk, .i_sys_rst, .i_k_clk, .i_k_clk_n, .i_rd_sel_n, .i_latency_mode_pin,
  .o_rd_data, .o_read_valid_flag, .o_echo_clock_out, .o_echo_clock_out_n);

// [tb/ddrsr_ctl_model.sv]
// Memory controller model: link clocks, address, selects and write data
`timescale 1ns/10ps
`include "ddrsr_params.svh"
module ddrsr_ctl_model (
  // Link pins toward the device
  output logic                     o_k,
  output logic                     o_k_n,
  output logic [`DDRSR_ADDR_W-1:0] o_addr,
  output logic                     o_rd_sel_n,
  output logic                     o_wr_sel_n,
  output logic [`DDRSR_DATA_W-1:0] o_wr_data
);
  logic [`DDRSR_DATA_W-1:0] pw0, pw1;
  logic                     pwr = 1'b0;
  // Free-running link clock, period 160 ns
  initial begin
    o_k = 1'b0;
    #204;
    forever begin
      o_k = ~o_k;
      #80;
    end
  end
  assign o_k_n = ~o_k;
  initial begin
    o_addr = '0;
    o_rd_sel_n = 1'b1;
    o_wr_sel_n = 1'b1;
    o_wr_data = '0;
  end
  // Entered at a write edge: data beats of the last write, read edge, write edge
  task automatic op(input logic rd, input logic [`DDRSR_ADDR_W-1:0] ra, input logic wr,
                    input logic [`DDRSR_ADDR_W-1:0] wa, input logic [`DDRSR_DATA_W-1:0] w0,
                    input logic [`DDRSR_DATA_W-1:0] w1);
    #40 o_wr_data = pwr ? pw0 : ~o_wr_data;
    #80 o_wr_data = pwr ? pw1 : ~o_wr_data;
    #8 o_addr = ra;
    o_rd_sel_n = ~rd;
    o_wr_sel_n = 1'b1;
    @(posedge o_k);
    #64 o_addr = wa;
    o_rd_sel_n = 1'b1;
    o_wr_sel_n = ~wr;
    @(posedge o_k);
    pw0 = w0;
    pw1 = w1;
    pwr = wr;
  endtask
endmodule

// [tb/test_ddr_dual_port_burst_sram_interface.sv]
// Self-checking bench for the burst SRAM interface
`timescale 1ns/10ps
`include "ddrsr_params.svh"
`define DDRSR_CHK(g, e) begin n_checks++; if ((g) !== (e)) begin fail_count++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module test_ddr_dual_port_burst_sram_interface;
  import ddrsr_pkg::*;
  logic        i_sys_clk, i_sys_rst, i_latency_mode_pin, k, k_n, rd_sel_n, wr_sel_n;
  logic        valid, echo, echo_n, stall;
  logic [7:0]  addr, last, wl [12];
  logic [17:0] wr_data, rd_data, e, m0 [256], m1 [256];
  logic [17:0] exp_q [$];
  int          fail_count = 0, n_checks = 0, seed = 32'h0697, i;
  ddrsr_ctl_model u_ctl (.o_k(k), .o_k_n(k_n), .o_addr(addr), .o_rd_sel_n(rd_sel_n),
                         .o_wr_sel_n(wr_sel_n), .o_wr_data(wr_data));
  ddrsr_core dut (.i_sys_clk, .i_sys_rst, .i_k_clk(k), .i_k_clk_n(k_n), .i_addr(addr),
    .i_rd_sel_n(rd_sel_n), .i_wr_sel_n(wr_sel_n), .i_wr_data(wr_data),
    .i_latency_mode_pin, .o_rd_data(rd_data), .o_read_valid_flag(valid),
    .o_echo_clock_out(echo), .o_echo_clock_out_n(echo_n), .o_wr_stall(stall));
  // System clock, 8 ns
  initial begin
    i_sys_clk = 1'b0;
    forever #4 i_sys_clk = ~i_sys_clk;
  end
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Issues one read edge and one write edge (two link periods) and notes the expected read words
  task automatic go(input logic rd, input logic [7:0] ra, input logic wr, input logic [7:0] wa);
    logic [17:0] w0, w1;
    w0 = 18'($random(seed));
    w1 = 18'($random(seed));
    if (rd) begin
      exp_q.push_back(m0[ra]);
      exp_q.push_back(m1[ra]);
    end
    if (wr) begin
      m0[wa] = w0;
      m1[wa] = w1;
    end
    u_ctl.op(rd, ra, wr, wa, w0, w1);
  endtask
  // Watches the read port, one sample in the middle of each beat
  initial begin
    forever begin
      @(negedge i_sys_clk);
      if (valid === 1'b1) begin
        repeat (5) @(negedge i_sys_clk);
        while (valid === 1'b1) begin
          `DDRSR_CHK(exp_q.size() > 0, 1'b1)
          e = exp_q.pop_front();
          `DDRSR_CHK(rd_data, e)
          repeat (10) @(negedge i_sys_clk);
        end
      end
    end
  end
  // Hang guard
  initial begin
    repeat (20000) @(posedge i_sys_clk);
    `DDRSR_CHK(1'b0, 1'b1)
    end_sim();
  end
  // Main sequence
  initial begin
    i_sys_rst = 1'b1;
    i_latency_mode_pin = 1'b0;
    repeat (4) @(posedge i_sys_clk);
    @(negedge i_sys_clk) i_sys_rst = 1'b0;
    last = 8'h00;
    for (i = 0; i < 12; i++) begin
      wl[i] = 8'($random(seed));
      go(i > 0, last, 1'b1, wl[i]);
      last = wl[i];
    end
    go(1'b1, last, 1'b0, 8'h00);
    go(1'b0, wl[0], 1'b0, 8'h00);
    go(1'b0, 8'h00, 1'b0, 8'h00);
    $display("short latency test done");
    @(negedge i_sys_clk) i_latency_mode_pin = 1'b1;
    for (i = 0; i < 12; i++) go(1'b1, wl[i], i[0], wl[i]);
    for (i = 0; i < 12; i++) go(1'b1, wl[i], 1'b0, 8'h00);
    go(1'b0, wl[1], 1'b0, 8'h00);
    for (i = 0; i < 200 && exp_q.size() > 0; i++) @(posedge i_sys_clk);
    repeat (20) @(posedge i_sys_clk);
    `DDRSR_CHK(exp_q.size(), 0)
    $display("long latency test done");
    end_sim();
  end
endmodule
